// ===== hw/dcrf_pkg.sv
// Package for the dual-edge RAM queue controller: sizes, codes, reset values
// and the packed carriers for the configuration port and the synchronised pins.
// Assumes a single system clock; both user clocks arrive as sampled pins.
package dcrf_pkg;

    // Storage geometry
    localparam int DCRF_DATA_W   = 36;   // Widest configured word
    localparam int DCRF_WORDS    = 32;   // Words held by the buffer
    localparam int DCRF_PTR_W    = 6;    // Pointer with wrap bit
    localparam int DCRF_OCC_W    = 16;   // Occupancy difference width
    localparam int DCRF_THR_W    = 8;    // Threshold input width
    localparam int DCRF_SYNC_LEN = 2;    // Flip-flops in each synchroniser

    // Depth code: capacity is two words shifted left by the code (0..4)
    localparam logic [2:0] DCRF_DEPTH_MAX  = 3'h4;
    localparam logic [3:0] DCRF_THR_BITS0  = 4'h4;   // Significant bits at code 0
    localparam logic [3:0] DCRF_OCC_SHIFT0 = 4'hE;   // Scale shift at code 0

    // Width codes
    localparam logic [2:0] DCRF_W1  = 3'h0;
    localparam logic [2:0] DCRF_W2  = 3'h1;
    localparam logic [2:0] DCRF_W4  = 3'h2;
    localparam logic [2:0] DCRF_W9  = 3'h3;
    localparam logic [2:0] DCRF_W18 = 3'h4;
    localparam logic [2:0] DCRF_W36 = 3'h5;

    // Reset values
    localparam logic [DCRF_PTR_W-1:0]  DCRF_PTR_RST  = 6'h00;
    localparam logic [DCRF_DATA_W-1:0] DCRF_DATA_RST = 36'h0_0000_0000;
    localparam logic                   DCRF_FULL_RST = 1'b0;
    localparam logic                   DCRF_EMPT_RST = 1'b1;

    // Static configuration, driven by fabric logic
    typedef struct packed {
        logic                  wclk_fall;            // Write side acts on falling edge
        logic                  rclk_fall;            // Read side acts on falling edge
        logic                  pipe;                 // Extra read data stage
        logic [2:0]            depth;                // Depth / cascade code
        logic [2:0]            width;                // Width / cascade code
        logic [DCRF_THR_W-1:0] near_full_threshold;  // Near-full level
        logic [DCRF_THR_W-1:0] near_empty_threshold; // Near-empty level
    } dcrf_cfg_t;

    // Everything that comes from outside and must be synchronised
    typedef struct packed {
        logic                   wclk;
        logic                   rclk;
        logic                   push_en;
        logic                   pop_en;
        logic                   queue_clear;
        dcrf_cfg_t              cfg;
        logic [DCRF_DATA_W-1:0] push_data;
    } dcrf_pins_t;

endpackage

// ===== hw/dcrf_ctrl.sv
// Queue controller with selectable clock polarity per side, and its buffer.
// Assumes both user clocks toggle slower than half of clk, with enables and
// data held steady around their active edge.
`timescale 1ns/1ns

// Plain ring buffer with valid/ready on both sides
module dcrf_buffer #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 32
) (
    // Clock, reset and flush
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];   // Word storage
    logic [AW-1:0]    wr_idx;        // Next slot to fill
    logic [AW-1:0]    rd_idx;        // Next slot to drain
    logic [AW:0]      count;         // Words held

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_idx];

    // Storage has no reset; only the indices and the count carry state
    always_ff @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem[wr_idx] <= in_data;
        end
    end

    // Index and count bookkeeping
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_idx <= '0;
            rd_idx <= '0;
            count  <= '0;
        end else if (flush) begin
            wr_idx <= '0;
            rd_idx <= '0;
            count  <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wr_idx <= wr_idx + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_idx <= rd_idx + 1'b1;
            end
            count <= count + (AW+1)'(in_valid && in_ready) - (AW+1)'(out_valid && out_ready);
        end
    end
endmodule

module dcrf_ctrl (
    // Clock and reset
    input  wire logic                             clk,
    input  wire logic                             rst_n,
    // User clocks, sampled as pins
    input  wire logic                             wclk,
    input  wire logic                             rclk,
    // Write side
    input  wire logic                             push_en,
    input  wire logic [dcrf_pkg::DCRF_DATA_W-1:0] push_data,
    output logic                                  full_flag,
    output logic                                  near_full_flag,
    // Read side
    input  wire logic                             pop_en,
    output logic [dcrf_pkg::DCRF_DATA_W-1:0]      pop_data,
    output logic                                  empty_flag,
    output logic                                  near_empty_flag,
    // Configuration and clear
    input  wire dcrf_pkg::dcrf_cfg_t              cfg,
    input  wire logic                             queue_clear
);
    import dcrf_pkg::*;

    // Binary to gray, used on both counters
    function automatic logic [DCRF_PTR_W-1:0] to_gray(input logic [DCRF_PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    // Gray back to binary after the crossing
    function automatic logic [DCRF_PTR_W-1:0] from_gray(input logic [DCRF_PTR_W-1:0] g);
        logic [DCRF_PTR_W-1:0] b;
        b = g;
        for (int i = DCRF_PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // Occupancy in words scaled onto the 16-bit difference scale
    function automatic logic [DCRF_OCC_W-1:0] scale_occ(input logic [DCRF_PTR_W-1:0] occ,
                                                        input logic [2:0]            depth);
        logic [3:0] sh;
        sh = DCRF_OCC_SHIFT0 - {1'b0, depth};
        return DCRF_OCC_W'({10'h000, occ} << sh);
    endfunction

    // Threshold moved to the top byte, unused low bits cleared
    function automatic logic [DCRF_OCC_W-1:0] scale_thr(input logic [DCRF_THR_W-1:0] thr,
                                                        input logic [2:0]            depth);
        logic [3:0]            nbits;
        logic [DCRF_THR_W-1:0] keep;
        nbits = DCRF_THR_BITS0 + {1'b0, depth};
        keep  = DCRF_THR_W'(8'hFF << (4'h8 - nbits));
        return {thr & keep, 8'h00};
    endfunction

    // Mask of live data bits for a width code
    function automatic logic [DCRF_DATA_W-1:0] width_mask(input logic [2:0] code);
        case (code)
            DCRF_W1:  return 36'h0_0000_0001;
            DCRF_W2:  return 36'h0_0000_0003;
            DCRF_W4:  return 36'h0_0000_000F;
            DCRF_W9:  return 36'h0_0000_01FF;
            DCRF_W18: return 36'h0_0003_FFFF;
            default:  return 36'hF_FFFF_FFFF;
        endcase
    endfunction

    // Pin synchroniser: stage 1 feeds stage 2 only
    dcrf_pins_t pins_raw;
    dcrf_pins_t pins_s1;
    dcrf_pins_t pins_s2;
    logic       wclk_s3;       // Delayed copy for edge detection
    logic       rclk_s3;

    assign pins_raw = '{wclk: wclk, rclk: rclk, push_en: push_en, pop_en: pop_en,
                        queue_clear: queue_clear, cfg: cfg, push_data: push_data};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_s1 <= '0;
            pins_s2 <= '0;
            wclk_s3 <= 1'b0;
            rclk_s3 <= 1'b0;
        end else begin
            pins_s1 <= pins_raw;
            pins_s2 <= pins_s1;
            wclk_s3 <= pins_s2.wclk;
            rclk_s3 <= pins_s2.rclk;
        end
    end

    // Active edge per side; polarity chosen independently
    logic wr_edge;
    logic rd_edge;
    logic clr;
    logic [2:0] depth_c;
    assign wr_edge = pins_s2.cfg.wclk_fall ? (wclk_s3 & ~pins_s2.wclk)
                                           : (~wclk_s3 & pins_s2.wclk);
    assign rd_edge = pins_s2.cfg.rclk_fall ? (rclk_s3 & ~pins_s2.rclk)
                                           : (~rclk_s3 & pins_s2.rclk);
    assign clr     = pins_s2.queue_clear;
    // Out-of-range depth codes fall back to the largest arrangement
    assign depth_c = (pins_s2.cfg.depth > DCRF_DEPTH_MAX) ? DCRF_DEPTH_MAX : pins_s2.cfg.depth;

    // Buffer handshake
    logic                   buf_in_ready;
    logic                   buf_out_valid;
    logic [DCRF_DATA_W-1:0] buf_out_data;
    logic                   buf_push;
    logic                   buf_pop;

    // Buffer back-pressure also blocks a push, as a second guard behind the flag
    assign buf_push = wr_edge && pins_s2.push_en && !full_flag && buf_in_ready && !clr;
    assign buf_pop  = rd_edge && pins_s2.pop_en && !empty_flag && buf_out_valid && !clr;

    dcrf_buffer #(
        .WIDTH (DCRF_DATA_W),
        .DEPTH (DCRF_WORDS)
    ) u_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .flush     (clr),
        .in_valid  (buf_push),
        .in_ready  (buf_in_ready),
        .in_data   (pins_s2.push_data & width_mask(pins_s2.cfg.width)),
        .out_valid (buf_out_valid),
        .out_ready (buf_pop),
        .out_data  (buf_out_data)
    );

    // Write and read counters, each with its gray copy
    logic [DCRF_PTR_W-1:0] wr_bin;
    logic [DCRF_PTR_W-1:0] rd_bin;
    logic [DCRF_PTR_W-1:0] wr_gray;
    logic [DCRF_PTR_W-1:0] rd_gray;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_bin  <= DCRF_PTR_RST;
            wr_gray <= DCRF_PTR_RST;
        end else if (clr) begin
            wr_bin  <= DCRF_PTR_RST;
            wr_gray <= DCRF_PTR_RST;
        end else if (buf_push) begin
            wr_bin  <= wr_bin + 1'b1;
            wr_gray <= to_gray(wr_bin + 1'b1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_bin  <= DCRF_PTR_RST;
            rd_gray <= DCRF_PTR_RST;
        end else if (clr) begin
            rd_bin  <= DCRF_PTR_RST;
            rd_gray <= DCRF_PTR_RST;
        end else if (buf_pop) begin
            rd_bin  <= rd_bin + 1'b1;
            rd_gray <= to_gray(rd_bin + 1'b1);
        end
    end

    // Each side sees the other counter only through two flops of gray code,
    // so the block still works if the sides are later split into real domains
    logic [DCRF_PTR_W-1:0] wg_s1;
    logic [DCRF_PTR_W-1:0] wg_s2;
    logic [DCRF_PTR_W-1:0] rg_s1;
    logic [DCRF_PTR_W-1:0] rg_s2;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wg_s1 <= DCRF_PTR_RST;
            wg_s2 <= DCRF_PTR_RST;
            rg_s1 <= DCRF_PTR_RST;
            rg_s2 <= DCRF_PTR_RST;
        end else begin
            wg_s1 <= wr_gray;
            wg_s2 <= wg_s1;
            rg_s1 <= rd_gray;
            rg_s2 <= rg_s1;
        end
    end

    // Occupancy as each side sees it; stale copies err on the safe side
    logic [DCRF_PTR_W-1:0] occ_w;
    logic [DCRF_PTR_W-1:0] occ_r;
    logic [DCRF_PTR_W-1:0] capacity;
    logic [DCRF_OCC_W-1:0] occupancy_a;
    logic [DCRF_OCC_W-1:0] occupancy_r;
    assign occ_w       = wr_bin - from_gray(rg_s2);
    assign occ_r       = from_gray(wg_s2) - rd_bin;
    assign capacity    = DCRF_PTR_W'(6'h02 << depth_c);
    assign occupancy_a = scale_occ(occ_w, depth_c);
    assign occupancy_r = scale_occ(occ_r, depth_c);

    // Write-side flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            full_flag      <= DCRF_FULL_RST;
            near_full_flag <= DCRF_FULL_RST;
        end else if (clr) begin
            full_flag      <= DCRF_FULL_RST;
            near_full_flag <= DCRF_FULL_RST;
        end else begin
            full_flag      <= (occ_w >= capacity);
            near_full_flag <= (occupancy_a >= scale_thr(pins_s2.cfg.near_full_threshold,
                                                        depth_c));
        end
    end

    // Read-side flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            empty_flag      <= DCRF_EMPT_RST;
            near_empty_flag <= DCRF_EMPT_RST;
        end else if (clr) begin
            empty_flag      <= DCRF_EMPT_RST;
            near_empty_flag <= DCRF_EMPT_RST;
        end else begin
            empty_flag      <= (occ_r == '0);
            near_empty_flag <= (scale_thr(pins_s2.cfg.near_empty_threshold,
                                          depth_c) >= occupancy_r);
        end
    end

    // Read data path: fetch register, then optional extra stage
    logic [DCRF_DATA_W-1:0] data_q;
    logic [DCRF_DATA_W-1:0] pipe_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_q   <= DCRF_DATA_RST;
            pipe_q   <= DCRF_DATA_RST;
            pop_data <= DCRF_DATA_RST;
        end else begin
            if (buf_pop) begin
                data_q <= buf_out_data & width_mask(pins_s2.cfg.width);
            end
            pipe_q   <= data_q;
            // Pipe trades one clk of latency for a cleaner output path
            pop_data <= pins_s2.cfg.pipe ? pipe_q : data_q;
        end
    end

    // Checks
    chk_full_blocks_push: assert property (@(posedge clk) disable iff (!rst_n)
        full_flag && !clr |=> $stable(wr_bin)) else $error("write count moved while full");

    chk_empty_blocks_pop: assert property (@(posedge clk) disable iff (!rst_n)
        empty_flag && !clr |=> $stable(rd_bin)) else $error("read count moved while empty");

    chk_push_bumps_count: assert property (@(posedge clk) disable iff (!rst_n)
        buf_push |=> (wr_bin == $past(wr_bin) + 6'h01)) else $error("write count did not advance");

    chk_clear_sets_flags: assert property (@(posedge clk) disable iff (!rst_n)
        clr |=> (empty_flag && near_empty_flag && !full_flag && !near_full_flag))
        else $error("clear left flags wrong");

    chk_write_edge_sense: assert property (@(posedge clk) disable iff (!rst_n)
        wr_edge |-> (pins_s2.wclk == !pins_s2.cfg.wclk_fall) && (wclk_s3 != pins_s2.wclk))
        else $error("write edge on wrong polarity");

    chk_read_edge_sense: assert property (@(posedge clk) disable iff (!rst_n)
        rd_edge |-> (pins_s2.rclk == !pins_s2.cfg.rclk_fall) && (rclk_s3 != pins_s2.rclk))
        else $error("read edge on wrong polarity");

    chk_pop_data_nopipe: assert property (@(posedge clk) disable iff (!rst_n)
        (buf_pop && !pins_s2.cfg.pipe) ##1 !pins_s2.cfg.pipe |=> (pop_data == $past(data_q)))
        else $error("unpiped read data late");

    chk_pop_data_pipe: assert property (@(posedge clk) disable iff (!rst_n)
        (buf_pop && pins_s2.cfg.pipe) ##1 pins_s2.cfg.pipe ##1 pins_s2.cfg.pipe
        |=> (pop_data == $past(data_q, 2))) else $error("piped read data not one stage later");

    chk_gray_one_step: assert property (@(posedge clk) disable iff (!rst_n)
        !clr && !$past(clr) |-> $countones(wr_gray ^ $past(wr_gray)) <= 1)
        else $error("write gray count moved more than one bit");
endmodule

// ===== sim/dcrf_user_model.sv
// User fabric model: drives the write and read clock pins, enables and data.
// Assumes one caller at a time, entering each task just after a clk rising edge.
`timescale 1ns/1ns

module dcrf_user_model (
    // Pacing clock
    input  wire logic                        clk,
    // Chosen active edges
    input  wire logic                        wclk_fall,
    input  wire logic                        rclk_fall,
    // Pins toward the queue
    output logic                             wclk,
    output logic                             rclk,
    output logic                             push_en,
    output logic [dcrf_pkg::DCRF_DATA_W-1:0] push_data,
    output logic                             pop_en,
    // One-cycle note that a read has settled
    output logic                             pop_done
);
    import dcrf_pkg::*;

    // Quiet pins at time zero
    initial begin
        wclk      = 1'b0;
        rclk      = 1'b0;
        push_en   = 1'b0;
        push_data = '0;
        pop_en    = 1'b0;
        pop_done  = 1'b0;
    end

    // Clocks rest at their inactive level, so no edge is seen between transfers
    task automatic park();
        wclk = wclk_fall;
        rclk = rclk_fall;
    endtask

    // One write clock cycle; phases of 4 clk keep both edges visible
    task automatic write_op(input logic en, input logic [DCRF_DATA_W-1:0] d, input int gap);
        push_en   = en;
        push_data = d;
        @(posedge clk); #1;
        wclk = ~wclk_fall;
        repeat (4) @(posedge clk); #1;
        wclk = wclk_fall;
        repeat (4) @(posedge clk); #1;
        // Released bus shows the inverse, never a stale copy
        push_en   = 1'b0;
        push_data = ~d;
        repeat (gap) @(posedge clk); #1;
    endtask

    // One read clock cycle; the gap lets a slow reader be modelled
    task automatic read_op(input logic en, input int gap);
        pop_en = en;
        @(posedge clk); #1;
        rclk = ~rclk_fall;
        repeat (4) @(posedge clk); #1;
        rclk = rclk_fall;
        repeat (4) @(posedge clk); #1;
        pop_en = 1'b0;
        repeat (gap) @(posedge clk); #1;
        pop_done = 1'b1;
        @(posedge clk); #1;
        pop_done = 1'b0;
    endtask
endmodule

// ===== sim/dcrf_ctrl_tb.sv
// Self-checking bench for the queue controller with a user fabric model.
// Assumes the package constants and the design's hand-over latencies.
`timescale 1ns/1ns

module dcrf_ctrl_tb;
    import dcrf_pkg::*;

    logic                   clk, rst_n, queue_clear;                  // Clock, reset, clear
    dcrf_cfg_t              cfg;                                      // Static setup
    logic                   wclk, rclk, push_en, pop_en, pop_done;    // Model pins
    logic [DCRF_DATA_W-1:0] push_data, pop_data;                      // Data buses
    logic                   full_flag, near_full_flag;                // Write side flags
    logic                   empty_flag, near_empty_flag;              // Read side flags
    int                     fail_count, n_compared, cap;              // Counters, capacity
    logic [DCRF_DATA_W-1:0] exp_q[$];                                 // Expected read words
    logic [DCRF_DATA_W-1:0] model_q[$];                               // Bench view of content
    logic [DCRF_DATA_W-1:0] last_word;                                // Read bus holds this

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    dcrf_ctrl dut (.clk(clk), .rst_n(rst_n), .wclk(wclk), .rclk(rclk), .push_en(push_en),
        .push_data(push_data), .full_flag(full_flag), .near_full_flag(near_full_flag),
        .pop_en(pop_en), .pop_data(pop_data), .empty_flag(empty_flag),
        .near_empty_flag(near_empty_flag), .cfg(cfg), .queue_clear(queue_clear));

    dcrf_user_model user (.clk(clk), .wclk_fall(cfg.wclk_fall), .rclk_fall(cfg.rclk_fall),
        .wclk(wclk), .rclk(rclk), .push_en(push_en), .push_data(push_data), .pop_en(pop_en),
        .pop_done(pop_done));

    // Single comparison point
    task automatic check(input logic [DCRF_DATA_W-1:0] seen, input logic [DCRF_DATA_W-1:0] exp,
                         input string what);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Bits kept by each width code
    function automatic logic [DCRF_DATA_W-1:0] wmask(input logic [2:0] w);
        case (w)
            DCRF_W1:  return 36'h0_0000_0001;
            DCRF_W2:  return 36'h0_0000_0003;
            DCRF_W4:  return 36'h0_0000_000F;
            DCRF_W9:  return 36'h0_0000_01FF;
            DCRF_W18: return 36'h0_0003_FFFF;
            default:  return 36'hF_FFFF_FFFF;
        endcase
    endfunction

    // Flags from the bench's own count; only the top 4+depth threshold bits count
    task automatic check_flags();
        logic [15:0] occ;
        logic [7:0]  msk;
        logic [3:0]  e;
        logic [2:0]  dc;
        // Out-of-range depth codes behave as the largest arrangement
        dc  = (cfg.depth > DCRF_DEPTH_MAX) ? DCRF_DEPTH_MAX : cfg.depth;
        occ = 16'(model_q.size() << (14 - dc));
        msk = 8'hFF << (4 - dc);
        e = {model_q.size() == cap, occ >= {cfg.near_full_threshold & msk, 8'h00},
             model_q.size() == 0, {cfg.near_empty_threshold & msk, 8'h00} >= occ};
        // A held clear forces both write-side flags low, whatever the threshold
        if (queue_clear) begin
            e = 4'h3;
        end
        check(36'({full_flag, near_full_flag, empty_flag, near_empty_flag}), 36'(e), "flags");
    endtask

    // Write; a full queue or a held clear drops the word
    task automatic push(input logic en);
        logic [DCRF_DATA_W-1:0] d;
        d = {4'($urandom), 32'($urandom)};
        if (en && !queue_clear && model_q.size() < cap) begin
            model_q.push_back(d & wmask(cfg.width));
        end
        user.write_op(en, d, $urandom_range(1, 4));
        check_flags();
    endtask

    // Read; an empty queue leaves the read bus holding its last word
    task automatic pop(input logic en);
        if (en && model_q.size() > 0) begin
            last_word = model_q.pop_front();
        end
        exp_q.push_back(last_word);
        user.read_op(en, $urandom_range(1, 4));
        check_flags();
    endtask

    // Watches the read bus whenever the model reports a settled read
    always @(posedge clk) begin
        if (pop_done === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(36'h0_0000_0001, 36'h0_0000_0000, "unexpected read");
            end else begin
                check(pop_data, exp_q.pop_front(), "read word");
            end
        end
    end

    // Reset into a new setup, then fill, overfill, drain, overdrain and clear
    task automatic run_cfg(input logic wf, input logic rf, input logic pp,
                           input logic [2:0] dp, input logic [2:0] wd);
        rst_n = 1'b0;
        cfg   = '{wf, rf, pp, dp, wd, 8'($urandom), 8'($urandom)};
        cap   = 2 << ((dp > DCRF_DEPTH_MAX) ? DCRF_DEPTH_MAX : dp);
        model_q.delete();
        last_word = '0;
        repeat (2) @(posedge clk); #1;
        user.park();
        repeat (2) @(posedge clk); #1;
        rst_n = 1'b1;
        repeat (4) @(posedge clk); #1;
        check(pop_data, '0, "reset word");
        check_flags();
        for (int i = 0; i <= cap; i++) push(1'b1);
        push(1'b0);
        pop(1'b0);
        for (int i = 0; i <= cap; i++) pop(1'b1);
        push(1'b1);
        push(1'b1);
        pop(1'b1);
        // Clear with a word left; a write while clearing is dropped
        queue_clear = 1'b1;
        model_q.delete();
        repeat (4) @(posedge clk); #1;
        push(1'b1);
        queue_clear = 1'b0;
        repeat (4) @(posedge clk); #1;
        pop(1'b1);
    endtask

    // Main sequence: every width code, both edge choices per side, pipe on and off
    initial begin
        rst_n       = 1'b0;
        queue_clear = 1'b0;
        cfg         = '0;
        fail_count  = 0;
        n_compared  = 0;
        cap         = 2;
        last_word   = '0;
        void'($urandom(32'h245b8078));
        repeat (12) @(posedge clk); #1;
        run_cfg(1'b0, 1'b0, 1'b0, 3'h0, DCRF_W1);
        run_cfg(1'b1, 1'b0, 1'b1, 3'h1, DCRF_W2);
        run_cfg(1'b0, 1'b1, 1'b0, 3'h2, DCRF_W4);
        run_cfg(1'b1, 1'b1, 1'b1, 3'h3, DCRF_W9);
        run_cfg(1'b0, 1'b0, 1'b1, 3'h4, DCRF_W18);
        run_cfg(1'b1, 1'b1, 1'b0, 3'h2, DCRF_W36);
        run_cfg(1'b0, 1'b1, 1'b1, 3'h7, 3'h7);
        for (int i = 0; i < 40 && exp_q.size() > 0; i++) begin
            @(posedge clk);
        end
        if (exp_q.size() > 0) begin
            check(36'(exp_q.size()), 36'h0_0000_0000, "reads left unseen");
        end
        tally_and_finish();
    end

    // Cut a hang short
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        $display("[FAIL] %0t run did not finish in time", $time);
        tally_and_finish();
    end
endmodule
